//--- include/pcf_pkg.sv
/*
  Constants, register map and carrier types for the point cloud packet output framer.
  Assumes one 50 MHz clock and a synchronous active-high reset.
*/
// Functional notes
// - append a 4-byte CRC-32 over pre-header through tail bytes; the framer computes it over payload bytes only
// - 16-byte AES-128-CMAC signature follows, over payload plus checksum
// - signature is all zeros until a key is set and a session started
// - source address defaults 192.168.1.201/255.255.255.0, gateway 192.168.1.1
// - tagging off by default; identifier limited to 1..4094
// - configured VLAN identifier survives firmware upgrades
// - tagging on drops time-sync link; tagging off restores it
// - refuse 0.0.0.0, 127.0.0.1, own address as destination; default broadcast
// - destination modes: broadcast, multicast group, unicast host
// - point cloud destination port configurable, default 2368
// - fault message destination port configurable, default 2368
// - diagnostics switch on by default gates fault packets and freeze frames
// - each fault captures a status snapshot as a freeze frame
// - single first/strongest or dual mode; active mode reported per packet
// - mode codes: 0x37 strongest, 0x33 first, 0x3C first and strongest
package pcf_pkg;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_VLAN_ID   = 8'h04;
  localparam logic [7:0]  REG_SRC_IP    = 8'h08;
  localparam logic [7:0]  REG_SRC_MASK  = 8'h0C;
  localparam logic [7:0]  REG_SRC_GW    = 8'h10;
  localparam logic [7:0]  REG_DST_IP    = 8'h14;
  localparam logic [7:0]  REG_DST_PORTS = 8'h18;
  localparam logic [7:0]  REG_STATUS    = 8'h1C;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h20;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h24;
  localparam logic [7:0]  REG_FREEZE    = 8'h28;
  localparam int          CTRL_VLAN_EN  = 0;
  localparam int          CTRL_DIAG_EN  = 1;
  localparam int          CTRL_SESSION  = 2;
  localparam int          CTRL_MODE_LSB = 8;
  localparam int          PORT_FLT_LSB  = 16;
  localparam int          IRQ_FAULT     = 0;
  localparam int          IRQ_ADDR_REJ  = 1;
  localparam int          IRQ_FRAME     = 2;
  localparam int          IRQ_CFG_REJ   = 3;
  localparam logic [31:0] RST_SRC_IP    = 32'hC0A801C9;
  localparam logic [31:0] RST_SRC_MASK  = 32'hFFFFFF00;
  localparam logic [31:0] RST_SRC_GW    = 32'hC0A80101;
  localparam logic [31:0] RST_DST_IP    = 32'hFFFFFFFF;
  localparam logic [31:0] IP_ZERO       = 32'h00000000;
  localparam logic [31:0] IP_LOOPBACK   = 32'h7F000001;
  localparam logic [15:0] RST_PORT      = 16'h0940;
  localparam logic [11:0] VLAN_ID_MIN   = 12'h001;
  localparam logic [11:0] VLAN_ID_MAX   = 12'hFFE;
  localparam logic [15:0] VLAN_TPID     = 16'h8100;
  localparam logic [7:0]  MODE_STRONG   = 8'h37;
  localparam logic [7:0]  MODE_FIRST    = 8'h33;
  localparam logic [7:0]  MODE_DUAL     = 8'h3C;
  localparam logic [31:0] CRC_POLY      = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [5:0]  MAC_ADDR_LAST = 6'h0B;
  localparam logic [5:0]  HDR_LAST      = 6'h29;
  localparam logic [5:0]  CRC_LAST      = 6'h03;
  localparam logic [5:0]  SIG_LAST      = 6'h0F;
  localparam logic [5:0]  FCS_LAST      = 6'h03;
  localparam logic [1:0]  TAG_LAST      = 2'h3;
  typedef enum logic [1:0] {DST_BCAST, DST_MCAST, DST_UCAST} pcf_dst_e;
  typedef enum {ST_HDR, ST_TAG, ST_PAY, ST_CRC, ST_WAIT, ST_SIG, ST_FCS} pcf_state_e;
  typedef struct packed {
    logic [31:0] src_ip;
    logic [31:0] src_mask;
    logic [31:0] src_gw;
    logic [31:0] dst_ip;
    logic [15:0] pc_port;
    logic [15:0] fault_port;
    logic        vlan_en;
    logic [11:0] vlan_id;
  } pcf_net_cfg_s;
endpackage : pcf_pkg

//--- verilog/pcf_framer.sv
/*
  Point cloud packet output framer: passes the header and payload byte stream,
  inserts the VLAN tag, appends checksum, signature and frame check sequence,
  holds addressing, diagnostics and return mode settings.
  Assumes the byte stream, register port and CMAC engine share CLK_SYS_IN,
  and that the transmit side takes one byte per cycle without stalling.
*/
`timescale 1ns/10ps
module pcf_framer (
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RST_IN,
  input  wire logic [7:0]            ADDR_IN,
  input  wire logic [31:0]           WR_DATA_IN,
  input  wire logic                  WR_EN_IN,
  input  wire logic                  RD_EN_IN,
  output logic      [31:0]           RD_DATA_OUT,
  input  wire logic                  IN_VALID_IN,
  input  wire logic [7:0]            IN_DATA_IN,
  input  wire logic                  IN_LAST_IN,
  output logic                       IN_READY_OUT,
  output logic                       TX_VALID_OUT,
  output logic      [7:0]            TX_DATA_OUT,
  output logic                       TX_LAST_OUT,
  output logic                       MAC_VALID_OUT,
  output logic      [7:0]            MAC_DATA_OUT,
  output logic                       MAC_LAST_OUT,
  input  wire logic                  MAC_TAG_VALID_IN,
  input  wire logic [127:0]          MAC_TAG_IN,
  input  wire logic                  FAULT_IN,
  input  wire logic [31:0]           FAULT_INFO_IN,
  output logic                       FAULT_PKT_OUT,
  output pcf_pkg::pcf_net_cfg_s      NET_CFG_OUT,
  output logic      [7:0]            RET_MODE_OUT,
  output logic                       PTP_LINK_EN_OUT,
  output logic                       IRQ_OUT
);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ pcf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // configuration group
  logic [31:0] src_ip_r, src_ip_nxt, mask_r, mask_nxt, gw_r, gw_nxt, dst_r, dst_nxt;
  logic [15:0] pc_port_r, pc_port_nxt, flt_port_r, flt_port_nxt;
  logic        vlan_en_r, vlan_en_nxt, diag_r, diag_nxt, sess_r, sess_nxt;
  logic [11:0] vlan_id_r = 12'h000;
  logic [11:0] vlan_id_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [3:0]  irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt;
  logic [31:0] freeze_r, freeze_nxt, rd_r, rd_nxt;
  logic        flt_pkt_r, flt_pkt_nxt, ptp_r, ptp_nxt, irq_r, irq_nxt;
  logic        frame_done;
  logic [1:0]  dst_mode;
  logic        vid_ok, mode_ok, dst_ok;

  // framer group
  pcf_pkg::pcf_state_e state_r, state_nxt;
  logic [5:0]   cnt_r, cnt_nxt;
  logic [1:0]   tcnt_r, tcnt_nxt;
  logic [31:0]  pcrc_r, pcrc_nxt, fcs_r, fcs_nxt, crc_res, fcs_res;
  logic [127:0] tag_r, tag_nxt;
  logic         rdy_r, rdy_nxt, txv_r, txv_nxt, txl_r, txl_nxt;
  logic [7:0]   txd_r, txd_nxt, macd_r, macd_nxt;
  logic         macv_r, macv_nxt, macl_r, macl_nxt;
  logic         in_acc, ov;
  logic [7:0]   ob;
  logic [31:0]  vtag;

  always_comb begin
    vid_ok  = (WR_DATA_IN[11:0] >= pcf_pkg::VLAN_ID_MIN)
            && (WR_DATA_IN[11:0] <= pcf_pkg::VLAN_ID_MAX);
    mode_ok = (WR_DATA_IN[pcf_pkg::CTRL_MODE_LSB +: 8] == pcf_pkg::MODE_STRONG)
            || (WR_DATA_IN[pcf_pkg::CTRL_MODE_LSB +: 8] == pcf_pkg::MODE_FIRST)
            || (WR_DATA_IN[pcf_pkg::CTRL_MODE_LSB +: 8] == pcf_pkg::MODE_DUAL);
    dst_ok  = (WR_DATA_IN != pcf_pkg::IP_ZERO) && (WR_DATA_IN != pcf_pkg::IP_LOOPBACK)
            && (WR_DATA_IN != src_ip_r);
    if (dst_r == pcf_pkg::RST_DST_IP) begin
      dst_mode = 2'(pcf_pkg::DST_BCAST);
    end else if (dst_r[31:28] == 4'hE) begin
      dst_mode = 2'(pcf_pkg::DST_MCAST);
    end else begin
      dst_mode = 2'(pcf_pkg::DST_UCAST);
    end
    src_ip_nxt   = src_ip_r;
    mask_nxt     = mask_r;
    gw_nxt       = gw_r;
    dst_nxt      = dst_r;
    pc_port_nxt  = pc_port_r;
    flt_port_nxt = flt_port_r;
    vlan_en_nxt  = vlan_en_r;
    vlan_id_nxt  = vlan_id_r;
    diag_nxt     = diag_r;
    sess_nxt     = sess_r;
    mode_nxt     = mode_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt   = irq_st_r;
    freeze_nxt   = freeze_r;
    flt_pkt_nxt  = 1'b0;
    rd_nxt       = rd_r;
    if (WR_EN_IN) begin
      case (ADDR_IN)
        pcf_pkg::REG_CTRL: begin
          diag_nxt = WR_DATA_IN[pcf_pkg::CTRL_DIAG_EN];
          sess_nxt = WR_DATA_IN[pcf_pkg::CTRL_SESSION];
          if (!WR_DATA_IN[pcf_pkg::CTRL_VLAN_EN] || vlan_id_r != 12'h000) begin
            vlan_en_nxt = WR_DATA_IN[pcf_pkg::CTRL_VLAN_EN];
          end else begin
            irq_st_nxt[pcf_pkg::IRQ_CFG_REJ] = 1'b1;
          end
          if (mode_ok) begin
            mode_nxt = WR_DATA_IN[pcf_pkg::CTRL_MODE_LSB +: 8];
          end else begin
            irq_st_nxt[pcf_pkg::IRQ_CFG_REJ] = 1'b1;
          end
        end
        pcf_pkg::REG_VLAN_ID: begin
          if (vid_ok) begin
            vlan_id_nxt = WR_DATA_IN[11:0];
          end else begin
            irq_st_nxt[pcf_pkg::IRQ_CFG_REJ] = 1'b1;
          end
        end
        pcf_pkg::REG_SRC_IP:   src_ip_nxt = WR_DATA_IN;
        pcf_pkg::REG_SRC_MASK: mask_nxt = WR_DATA_IN;
        pcf_pkg::REG_SRC_GW:   gw_nxt = WR_DATA_IN;
        pcf_pkg::REG_DST_IP: begin
          if (dst_ok) begin
            dst_nxt = WR_DATA_IN;
          end else begin
            irq_st_nxt[pcf_pkg::IRQ_ADDR_REJ] = 1'b1;
          end
        end
        pcf_pkg::REG_DST_PORTS: begin
          pc_port_nxt  = WR_DATA_IN[15:0];
          flt_port_nxt = WR_DATA_IN[pcf_pkg::PORT_FLT_LSB +: 16];
        end
        pcf_pkg::REG_IRQ_STAT: irq_st_nxt = irq_st_nxt & ~WR_DATA_IN[3:0];
        pcf_pkg::REG_IRQ_MASK: irq_mask_nxt = WR_DATA_IN[3:0];
        default: ;
      endcase
    end
    // hardware events win over a same-cycle clear
    if (FAULT_IN && diag_r) begin
      freeze_nxt  = FAULT_INFO_IN;
      flt_pkt_nxt = 1'b1;
      irq_st_nxt[pcf_pkg::IRQ_FAULT] = 1'b1;
    end
    if (frame_done) begin
      irq_st_nxt[pcf_pkg::IRQ_FRAME] = 1'b1;
    end
    if (RD_EN_IN) begin
      case (ADDR_IN)
        pcf_pkg::REG_CTRL:      rd_nxt = {16'h0000, mode_r, 5'h00, sess_r, diag_r, vlan_en_r};
        pcf_pkg::REG_VLAN_ID:   rd_nxt = {20'h00000, vlan_id_r};
        pcf_pkg::REG_SRC_IP:    rd_nxt = src_ip_r;
        pcf_pkg::REG_SRC_MASK:  rd_nxt = mask_r;
        pcf_pkg::REG_SRC_GW:    rd_nxt = gw_r;
        pcf_pkg::REG_DST_IP:    rd_nxt = dst_r;
        pcf_pkg::REG_DST_PORTS: rd_nxt = {flt_port_r, pc_port_r};
        pcf_pkg::REG_STATUS:    rd_nxt = {28'h0000000, ptp_r,
                                         (state_r != pcf_pkg::ST_HDR) || (cnt_r != 6'h00),
                                         dst_mode};
        pcf_pkg::REG_IRQ_STAT:  rd_nxt = {28'h0000000, irq_st_r};
        pcf_pkg::REG_IRQ_MASK:  rd_nxt = {28'h0000000, irq_mask_r};
        pcf_pkg::REG_FREEZE:    rd_nxt = diag_r ? freeze_r : 32'h00000000;
        default:                rd_nxt = 32'h00000000;
      endcase
    end
    ptp_nxt = !vlan_en_r;
    irq_nxt = |(irq_st_nxt & irq_mask_nxt);
  end

  always_ff @(posedge CLK_SYS_IN) begin
    vlan_id_r <= vlan_id_nxt;
    if (RST_IN) begin
      src_ip_r   <= pcf_pkg::RST_SRC_IP;
      mask_r     <= pcf_pkg::RST_SRC_MASK;
      gw_r       <= pcf_pkg::RST_SRC_GW;
      dst_r      <= pcf_pkg::RST_DST_IP;
      pc_port_r  <= pcf_pkg::RST_PORT;
      flt_port_r <= pcf_pkg::RST_PORT;
      vlan_en_r  <= 1'b0;
      diag_r     <= 1'b1;
      sess_r     <= 1'b0;
      mode_r     <= pcf_pkg::MODE_STRONG;
      irq_st_r   <= 4'h0;
      irq_mask_r <= 4'h0;
      freeze_r   <= 32'h00000000;
      flt_pkt_r  <= 1'b0;
      rd_r       <= 32'h00000000;
      ptp_r      <= 1'b1;
      irq_r      <= 1'b0;
    end else begin
      src_ip_r   <= src_ip_nxt;
      mask_r     <= mask_nxt;
      gw_r       <= gw_nxt;
      dst_r      <= dst_nxt;
      pc_port_r  <= pc_port_nxt;
      flt_port_r <= flt_port_nxt;
      vlan_en_r  <= vlan_en_nxt;
      diag_r     <= diag_nxt;
      sess_r     <= sess_nxt;
      mode_r     <= mode_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      freeze_r   <= freeze_nxt;
      flt_pkt_r  <= flt_pkt_nxt;
      rd_r       <= rd_nxt;
      ptp_r      <= ptp_nxt;
      irq_r      <= irq_nxt;
    end
  end

  always_comb begin
    in_acc     = IN_VALID_IN && rdy_r;
    crc_res    = ~pcrc_r;
    fcs_res    = ~fcs_r;
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    tcnt_nxt   = tcnt_r;
    pcrc_nxt   = pcrc_r;
    fcs_nxt    = fcs_r;
    tag_nxt    = tag_r;
    txl_nxt    = 1'b0;
    macv_nxt   = 1'b0;
    macl_nxt   = 1'b0;
    macd_nxt   = macd_r;
    frame_done = 1'b0;
    ov         = 1'b0;
    ob         = IN_DATA_IN;
    vtag       = {pcf_pkg::VLAN_TPID, 4'h0, vlan_id_r};
    case (state_r)
      pcf_pkg::ST_HDR: begin
        if (in_acc) begin
          ov      = 1'b1;
          cnt_nxt = cnt_r + 6'h01;
          if (IN_LAST_IN) begin
            state_nxt = pcf_pkg::ST_CRC;
            cnt_nxt   = 6'h00;
          end else if (cnt_r == pcf_pkg::MAC_ADDR_LAST && vlan_en_r) begin
            state_nxt = pcf_pkg::ST_TAG;
          end else if (cnt_r == pcf_pkg::HDR_LAST) begin
            state_nxt = pcf_pkg::ST_PAY;
          end
        end
      end
      pcf_pkg::ST_TAG: begin
        ov       = 1'b1;
        ob       = vtag[{~tcnt_r, 3'b000} +: 8];
        tcnt_nxt = tcnt_r + 2'h1;
        if (tcnt_r == pcf_pkg::TAG_LAST) begin
          state_nxt = pcf_pkg::ST_HDR;
        end
      end
      pcf_pkg::ST_PAY: begin
        if (in_acc) begin
          ov       = 1'b1;
          pcrc_nxt = crc_byte(pcrc_r, IN_DATA_IN);
          macv_nxt = sess_r;
          macd_nxt = IN_DATA_IN;
          if (IN_LAST_IN) begin
            state_nxt = pcf_pkg::ST_CRC;
            cnt_nxt   = 6'h00;
          end
        end
      end
      pcf_pkg::ST_CRC: begin
        ov       = 1'b1;
        ob       = crc_res[{cnt_r[1:0], 3'b000} +: 8];
        macv_nxt = sess_r;
        macd_nxt = ob;
        macl_nxt = sess_r && (cnt_r == pcf_pkg::CRC_LAST);
        cnt_nxt  = cnt_r + 6'h01;
        if (cnt_r == pcf_pkg::CRC_LAST) begin
          cnt_nxt   = 6'h00;
          tag_nxt   = 128'h0;
          state_nxt = sess_r ? pcf_pkg::ST_WAIT : pcf_pkg::ST_SIG;
        end
      end
      pcf_pkg::ST_WAIT: begin
        if (!sess_r) begin
          state_nxt = pcf_pkg::ST_SIG;
        end else if (MAC_TAG_VALID_IN) begin
          tag_nxt   = MAC_TAG_IN;
          state_nxt = pcf_pkg::ST_SIG;
        end
      end
      pcf_pkg::ST_SIG: begin
        ov      = 1'b1;
        ob      = tag_r[{~cnt_r[3:0], 3'b000} +: 8];
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == pcf_pkg::SIG_LAST) begin
          cnt_nxt   = 6'h00;
          state_nxt = pcf_pkg::ST_FCS;
        end
      end
      pcf_pkg::ST_FCS: begin
        ov      = 1'b1;
        ob      = fcs_res[{cnt_r[1:0], 3'b000} +: 8];
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == pcf_pkg::FCS_LAST) begin
          txl_nxt    = 1'b1;
          frame_done = 1'b1;
          cnt_nxt    = 6'h00;
          tcnt_nxt   = 2'h0;
          pcrc_nxt   = pcf_pkg::CRC_INIT;
          fcs_nxt    = pcf_pkg::CRC_INIT;
          state_nxt  = pcf_pkg::ST_HDR;
        end
      end
      default: state_nxt = pcf_pkg::ST_HDR;
    endcase
    if (ov && state_r != pcf_pkg::ST_FCS) begin
      fcs_nxt = crc_byte(fcs_r, ob);
    end
    txv_nxt = ov;
    txd_nxt = ov ? ob : txd_r;
    rdy_nxt = (state_nxt == pcf_pkg::ST_HDR) || (state_nxt == pcf_pkg::ST_PAY);
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_r <= pcf_pkg::ST_HDR;
      cnt_r   <= 6'h00;
      tcnt_r  <= 2'h0;
      pcrc_r  <= pcf_pkg::CRC_INIT;
      fcs_r   <= pcf_pkg::CRC_INIT;
      tag_r   <= 128'h0;
      rdy_r   <= 1'b0;
      txv_r   <= 1'b0;
      txl_r   <= 1'b0;
      txd_r   <= 8'h00;
      macv_r  <= 1'b0;
      macl_r  <= 1'b0;
      macd_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      tcnt_r  <= tcnt_nxt;
      pcrc_r  <= pcrc_nxt;
      fcs_r   <= fcs_nxt;
      tag_r   <= tag_nxt;
      rdy_r   <= rdy_nxt;
      txv_r   <= txv_nxt;
      txl_r   <= txl_nxt;
      txd_r   <= txd_nxt;
      macv_r  <= macv_nxt;
      macl_r  <= macl_nxt;
      macd_r  <= macd_nxt;
    end
  end

  assign RD_DATA_OUT     = rd_r;
  assign IN_READY_OUT    = rdy_r;
  assign TX_VALID_OUT    = txv_r;
  assign TX_DATA_OUT     = txd_r;
  assign TX_LAST_OUT     = txl_r;
  assign MAC_VALID_OUT   = macv_r;
  assign MAC_DATA_OUT    = macd_r;
  assign MAC_LAST_OUT    = macl_r;
  assign FAULT_PKT_OUT   = flt_pkt_r;
  assign NET_CFG_OUT     = {src_ip_r, mask_r, gw_r, dst_r, pc_port_r, flt_port_r,
                            vlan_en_r, vlan_id_r};
  assign RET_MODE_OUT    = mode_r;
  assign PTP_LINK_EN_OUT = ptp_r;
  assign IRQ_OUT         = irq_r;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence crc_end_s(logic s);
    state_r == pcf_pkg::ST_CRC && cnt_r == pcf_pkg::CRC_LAST && sess_r == s;
  endsequence

  chk_vlan_id_range: assert property (vlan_en_r |-> vlan_id_r >= pcf_pkg::VLAN_ID_MIN
    && vlan_id_r <= pcf_pkg::VLAN_ID_MAX) else $error("vlan enabled with bad id");
  chk_dst_legal: assert property (dst_r != pcf_pkg::IP_ZERO
    && dst_r != pcf_pkg::IP_LOOPBACK) else $error("illegal destination held");
  chk_crc_four_bytes: assert property ($rose(state_r == pcf_pkg::ST_CRC) |->
    (state_r == pcf_pkg::ST_CRC)[*4] ##1 state_r != pcf_pkg::ST_CRC)
    else $error("checksum not four bytes");
  chk_sig_zero_wait: assert property (crc_end_s(1'b0) |=>
    state_r == pcf_pkg::ST_SIG && tag_r == 128'h0) else $error("signature not zero");
  chk_mac_before_sig: assert property (crc_end_s(1'b1) |=>
    state_r == pcf_pkg::ST_WAIT && MAC_LAST_OUT) else $error("mac feed order broken");
  chk_sig_to_fcs: assert property (state_r == pcf_pkg::ST_SIG && cnt_r == pcf_pkg::SIG_LAST
    |=> state_r == pcf_pkg::ST_FCS ##4 TX_LAST_OUT && TX_VALID_OUT)
    else $error("signature or fcs length wrong");
  chk_ptp_follows_vlan: assert property (vlan_en_r |=> !PTP_LINK_EN_OUT)
    else $error("time sync kept with vlan on");
  chk_fault_gate_off: assert property (FAULT_IN && !diag_r |=> !FAULT_PKT_OUT)
    else $error("fault packet with diagnostics off");
  chk_freeze_capture: assert property (FAULT_IN && diag_r |=>
    freeze_r == $past(FAULT_INFO_IN) && FAULT_PKT_OUT) else $error("freeze frame missed");
  chk_mode_code: assert property (mode_r == pcf_pkg::MODE_STRONG
    || mode_r == pcf_pkg::MODE_FIRST || mode_r == pcf_pkg::MODE_DUAL)
    else $error("bad return mode code");
  chk_reset_addrs: assert property ($fell(RST_IN) |-> dst_r == pcf_pkg::RST_DST_IP
    && src_ip_r == pcf_pkg::RST_SRC_IP && pc_port_r == pcf_pkg::RST_PORT
    && flt_port_r == pcf_pkg::RST_PORT) else $error("reset defaults wrong");

endmodule : pcf_framer

//--- testbench/pcf_host_model.sv
/*
  Receiving host and signature engine model for the framer bench.
  Assumes one shared clock; answers each checksum end with a fixed tag.
*/
`timescale 1ns/10ps
module pcf_host_model #(
  parameter logic [127:0] TAG = 128'h0
) (
  input  wire logic         clk_in,
  input  wire logic         tx_valid_in,
  input  wire logic [7:0]   tx_data_in,
  input  wire logic         mac_valid_in,
  input  wire logic [7:0]   mac_data_in,
  input  wire logic         mac_last_in,
  output logic              tag_valid_out,
  output logic      [127:0] tag_out
);
  logic [7:0] rx_q[$];
  logic [7:0] mac_q[$];
  initial begin
    tag_valid_out = 1'b0;
    tag_out       = ~TAG;
  end
  // host keeps every emitted byte for the bench to inspect
  always @(posedge clk_in) begin
    if (tx_valid_in) rx_q.push_back(tx_data_in);
    if (mac_valid_in) mac_q.push_back(mac_data_in);
  end
  // engine answers a few cycles after the last checksum byte
  always @(posedge clk_in) begin
    if (mac_last_in) begin
      repeat (3) @(posedge clk_in);
      tag_valid_out <= 1'b1;
      tag_out       <= TAG;
      @(posedge clk_in);
      tag_valid_out <= 1'b0;
      tag_out       <= ~TAG;
    end
  end
endmodule : pcf_host_model

//--- testbench/pcf_framer_tb.sv
/*
  Self-checking bench for the point cloud packet output framer.
  Assumes pcf_pkg and the host model are compiled first.
*/
`timescale 1ns/10ps
module pcf_framer_tb;
  localparam logic [127:0] TAG = 128'h00112233445566778899AABBCCDDEEFF;
  logic                  CLK_SYS_IN = 1'b0;
  logic                  RST_IN = 1'b1;
  logic [7:0]            ADDR_IN = 8'h00;
  logic [31:0]           WR_DATA_IN = 32'h0;
  logic [31:0]           FAULT_INFO_IN = 32'h0;
  logic                  WR_EN_IN = 1'b0;
  logic                  RD_EN_IN = 1'b0;
  logic                  FAULT_IN = 1'b0;
  logic                  IN_VALID_IN = 1'b0;
  logic                  IN_LAST_IN = 1'b0;
  logic [7:0]            IN_DATA_IN = 8'h00;
  logic [31:0]           RD_DATA_OUT;
  logic [7:0]            TX_DATA_OUT, MAC_DATA_OUT, RET_MODE_OUT;
  logic                  IN_READY_OUT, TX_VALID_OUT, TX_LAST_OUT, MAC_VALID_OUT;
  logic                  MAC_LAST_OUT, MAC_TAG_VALID_IN, FAULT_PKT_OUT;
  logic                  PTP_LINK_EN_OUT, IRQ_OUT;
  logic [127:0]          MAC_TAG_IN;
  pcf_pkg::pcf_net_cfg_s NET_CFG_OUT;
  int                    fails = 0;
  int                    checks_done = 0;
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  pcf_framer dut (.*);
  pcf_host_model #(.TAG(TAG)) host (.clk_in(CLK_SYS_IN), .tx_valid_in(TX_VALID_OUT),
    .tx_data_in(TX_DATA_OUT), .mac_valid_in(MAC_VALID_OUT), .mac_data_in(MAC_DATA_OUT),
    .mac_last_in(MAC_LAST_OUT),
    .tag_valid_out(MAC_TAG_VALID_IN), .tag_out(MAC_TAG_IN));
  task automatic c(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : c
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS_IN);
    ADDR_IN    <= a;
    WR_DATA_IN <= d;
    WR_EN_IN   <= 1'b1;
    @(posedge CLK_SYS_IN);
    WR_EN_IN <= 1'b0;
    @(negedge CLK_SYS_IN);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_SYS_IN);
    ADDR_IN  <= a;
    RD_EN_IN <= 1'b1;
    @(posedge CLK_SYS_IN);
    RD_EN_IN <= 1'b0;
    @(negedge CLK_SYS_IN);
    c(RD_DATA_OUT, e);
  endtask : r
  task automatic rst;
    RST_IN <= 1'b1;
    repeat (12) @(posedge CLK_SYS_IN);
    RST_IN <= 1'b0;
    @(negedge CLK_SYS_IN);
  endtask : rst
  task automatic flt(input logic [31:0] info, input logic on);
    @(posedge CLK_SYS_IN);
    FAULT_IN      <= 1'b1;
    FAULT_INFO_IN <= info;
    @(posedge CLK_SYS_IN);
    FAULT_IN <= 1'b0;
    @(negedge CLK_SYS_IN);
    c(FAULT_PKT_OUT, on);
    r(pcf_pkg::REG_FREEZE, on ? info : 32'h0);
  endtask : flt
  function automatic logic [31:0] crc(input logic [7:0] b[$], input int lo);
    logic [31:0] k;
    k = pcf_pkg::CRC_INIT;
    for (int i = lo; i < b.size(); i++) begin
      k = k ^ {24'h0, b[i]};
      repeat (8) k = k[0] ? (k >> 1) ^ pcf_pkg::CRC_POLY : k >> 1;
    end
    return ~k;
  endfunction : crc
  // 42 header bytes, the tag when vid is not zero, 6 payload bytes, then the trailer
  task automatic frame(input logic [127:0] sig, input logic [11:0] vid);
    logic [7:0]  e[$];
    logic [31:0] k;
    logic        rdy;
    int          i;
    int          p;
    host.rx_q.delete();
    host.mac_q.delete();
    for (i = 0; i < 48; i++) begin
      e.push_back(8'(i));
      if (i == 11 && vid != 12'h000) begin
        e.push_back(8'h81);
        e.push_back(8'h00);
        e.push_back({4'h0, vid[11:8]});
        e.push_back(vid[7:0]);
      end
    end
    p = e.size() - 6;
    k = crc(e, p);
    for (i = 0; i < 4; i++) e.push_back(k[8*i+:8]);
    for (i = 15; i >= 0; i--) e.push_back(sig[8*i+:8]);
    k = crc(e, 0);
    for (i = 0; i < 4; i++) e.push_back(k[8*i+:8]);
    i = 0;
    @(posedge CLK_SYS_IN);
    while (i < 48) begin
      IN_VALID_IN <= 1'b1;
      IN_DATA_IN  <= 8'(i);
      IN_LAST_IN  <= (i == 47);
      @(negedge CLK_SYS_IN);
      rdy = IN_READY_OUT;
      @(posedge CLK_SYS_IN);
      if (rdy === 1'b1) i++;
    end
    IN_VALID_IN <= 1'b0;
    IN_LAST_IN  <= 1'b0;
    for (i = 0; i < 300 && TX_LAST_OUT !== 1'b1; i++) @(negedge CLK_SYS_IN);
    c(TX_LAST_OUT, 32'h1);
    @(negedge CLK_SYS_IN);
    c(32'(host.rx_q.size()), (vid != 12'h000) ? 32'd76 : 32'd72);
    for (i = 0; i < e.size(); i++) c(host.rx_q[i], e[i]);
    c(32'(host.mac_q.size()), (sig != 128'h0) ? 32'd10 : 32'd0);
    for (i = 0; i < host.mac_q.size(); i++) c(host.mac_q[i], e[p + i]);
  endtask : frame
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    static logic [31:0] bad[3] = '{32'h00000000, 32'h7F000001, 32'hC0A801C9};
    static logic [7:0]  md[3]  = '{8'h33, 8'h37, 8'h3C};
    rst();
    c(NET_CFG_OUT.src_ip, 32'hC0A801C9);
    c(NET_CFG_OUT.src_mask, 32'hFFFFFF00);
    c(NET_CFG_OUT.src_gw, 32'hC0A80101);
    c(NET_CFG_OUT.vlan_en, 32'h0);
    c(RET_MODE_OUT, 32'h37);
    r(pcf_pkg::REG_DST_IP, 32'hFFFFFFFF);
    r(pcf_pkg::REG_DST_PORTS, 32'h09400940);
    r(pcf_pkg::REG_CTRL, 32'h00003702);
    r(8'h3C, 32'h0);
    w(pcf_pkg::REG_IRQ_MASK, 32'h2);
    foreach (bad[j]) w(pcf_pkg::REG_DST_IP, bad[j]);
    r(pcf_pkg::REG_DST_IP, 32'hFFFFFFFF);
    c(IRQ_OUT, 32'h1);
    w(pcf_pkg::REG_IRQ_STAT, 32'h2);
    r(pcf_pkg::REG_IRQ_STAT, 32'h0);
    c(IRQ_OUT, 32'h0);
    w(pcf_pkg::REG_DST_IP, 32'hE0000101);
    r(pcf_pkg::REG_STATUS, 32'h9);
    w(pcf_pkg::REG_DST_IP, 32'h0A000001);
    r(pcf_pkg::REG_STATUS, 32'hA);
    c(NET_CFG_OUT.dst_ip, 32'h0A000001);
    w(pcf_pkg::REG_DST_PORTS, 32'h1F901234);
    c(NET_CFG_OUT.fault_port, 32'h1F90);
    c(NET_CFG_OUT.pc_port, 32'h1234);
    w(pcf_pkg::REG_CTRL, 32'h3703);
    c(NET_CFG_OUT.vlan_en, 32'h0);
    w(pcf_pkg::REG_VLAN_ID, 32'h0);
    w(pcf_pkg::REG_VLAN_ID, 32'hFFF);
    r(pcf_pkg::REG_VLAN_ID, 32'h0);
    w(pcf_pkg::REG_VLAN_ID, 32'hFFE);
    w(pcf_pkg::REG_CTRL, 32'h3703);
    r(pcf_pkg::REG_IRQ_STAT, 32'h8);
    c(PTP_LINK_EN_OUT, 32'h0);
    c(NET_CFG_OUT.vlan_id, 32'hFFE);
    w(pcf_pkg::REG_CTRL, 32'h3702);
    r(pcf_pkg::REG_STATUS, 32'hA);
    c(PTP_LINK_EN_OUT, 32'h1);
    @(posedge CLK_SYS_IN);
    rst();
    r(pcf_pkg::REG_VLAN_ID, 32'hFFE);
    foreach (md[j]) begin
      w(pcf_pkg::REG_CTRL, {16'h0, md[j], 8'h02});
      c(RET_MODE_OUT, md[j]);
    end
    w(pcf_pkg::REG_CTRL, 32'h5502);
    c(RET_MODE_OUT, 32'h3C);
    w(pcf_pkg::REG_IRQ_MASK, 32'h1);
    flt(32'hA5A50001, 1'b1);
    c(IRQ_OUT, 32'h1);
    w(pcf_pkg::REG_IRQ_STAT, 32'h1);
    w(pcf_pkg::REG_CTRL, 32'h3700);
    flt(32'h5A5A0002, 1'b0);
    c(IRQ_OUT, 32'h0);
    w(pcf_pkg::REG_CTRL, 32'h3702);
    frame(128'h0, 12'h000);
    w(pcf_pkg::REG_CTRL, 32'h3706);
    frame(TAG, 12'h000);
    w(pcf_pkg::REG_CTRL, 32'h3703);
    frame(128'h0, 12'hFFE);
    r(pcf_pkg::REG_IRQ_STAT, 32'hC);
    give_verdict();
  end
endmodule : pcf_framer_tb
